// *** hw/slc_pkg.sv ***
/*
  Package for the strap latch and LED control block: register offsets,
  reset values, field positions, timing constants and carrier structs.
  Assumes a 125 MHz core clock and a 32-bit Avalon-MM register bus.
*/
package slc_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned STRETCH_28_MS = 28;
  localparam int unsigned STRETCH_60_MS = 60;
  localparam int unsigned STRETCH_100_MS = 100;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned STRETCH_28_CYC = STRETCH_28_MS * CYC_PER_MS;
  localparam int unsigned STRETCH_60_CYC = STRETCH_60_MS * CYC_PER_MS;
  localparam int unsigned STRETCH_100_CYC = STRETCH_100_MS * CYC_PER_MS;
  localparam int unsigned BLINK_HALF_MS = 100;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;

  // ------------------------------------------------------------
  // register byte offsets (word aligned)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_STRAP = 8'h00;
  localparam logic [7:0] OFS_ADV = 8'h04;
  localparam logic [7:0] OFS_MACIF = 8'h08;
  localparam logic [7:0] OFS_LOWPWR = 8'h0c;
  localparam logic [7:0] OFS_LED_CTRL1 = 8'h6c;
  localparam logic [7:0] OFS_LED_CTRL2 = 8'h70;
  localparam logic [7:0] OFS_LED_CTRL3 = 8'h74;

  // ------------------------------------------------------------
  // led control fields
  // ------------------------------------------------------------
  localparam int unsigned LED_FN_W = 4;
  localparam int unsigned LED_FORCE_LSB = 4;
  localparam int unsigned LED_STRIDE = 8;
  localparam int unsigned STRETCH_SEL_LSB = 0;
  localparam int unsigned STRETCH_EN_BIT = 2;

  localparam logic [3:0] FN_ACT = 4'h0;
  localparam logic [3:0] FN_LINK_ACT = 4'h1;
  localparam logic [3:0] FN_DUP_COL = 4'h2;
  localparam logic [3:0] FN_LINK_RX = 4'h3;
  localparam logic [3:0] FN_DUPLEX = 4'h4;
  localparam logic [3:0] FN_COL = 4'h5;
  localparam logic [3:0] FN_1000 = 4'h6;
  localparam logic [3:0] FN_100 = 4'h7;
  localparam logic [3:0] FN_10 = 4'h8;
  localparam logic [3:0] FN_1000_100 = 4'h9;
  localparam logic [3:0] FN_LINK = 4'ha;
  localparam logic [3:0] FN_TX = 4'hb;
  localparam logic [3:0] FN_RX = 4'hc;

  localparam logic [1:0] FORCE_NONE = 2'h0;
  localparam logic [1:0] FORCE_ON = 2'h1;
  localparam logic [1:0] FORCE_OFF = 2'h2;
  localparam logic [1:0] FORCE_BLINK = 2'h3;

  // gigabit led: fn 1000, link led: fn link, general leds forced off
  localparam logic [31:0] LED_CTRL1_RST = 32'h0000_0a06;
  localparam logic [31:0] LED_CTRL2_RST = 32'h0000_2020;
  localparam logic [31:0] LED_CTRL3_RST = 32'h0000_0000;

  // ------------------------------------------------------------
  // mac interface mode values
  // ------------------------------------------------------------
  localparam logic [2:0] MACIF_RGMII_MODE = 3'h6;
  localparam logic [2:0] MACIF_RTBI_MODE = 3'h7;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic gig_adv;
    logic pause;
    logic sysclk_en_low;
    logic ed_en_low;
    logic [2:0] mac_sel;
    logic [3:0] led_pol;
  } slc_strap_t;

  typedef struct packed {
    logic link;
    logic duplex;
    logic col;
    logic tx;
    logic rx;
    logic sp1000;
    logic sp100;
    logic sp10;
  } slc_status_t;

endpackage : slc_pkg

// *** hw/slc_led_drv.sv ***
/*
  One LED driver: function select, force modes and event stretch; polarity is applied by the top.
  Assumes a shared blink phase and a stretch length chosen by the top.
*/
`timescale 1ns/1ps
module slc_led_drv
  import slc_pkg::*;
#(
  parameter int unsigned CNT_W = 24
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] ctrl_in,
  input wire slc_status_t status_in,
  input wire logic blink_in,
  input wire logic stretch_en_in,
  input wire logic [CNT_W-1:0] stretch_len_in,
  output logic lit_out
);

  // ------------------------------------------------------------
  // event and function decode
  // ------------------------------------------------------------
  logic [CNT_W-1:0] hold_reg;
  logic lit_reg;
  wire logic [3:0] fn = ctrl_in[LED_FN_W-1:0];
  wire logic [1:0] force_sel = ctrl_in[LED_FORCE_LSB +: 2];
  wire logic act = status_in.tx | status_in.rx;
  wire logic ev_raw = (fn == FN_ACT) ? act :
                      (fn == FN_COL) ? status_in.col :
                      (fn == FN_TX) ? status_in.tx :
                      (fn == FN_RX) ? status_in.rx : 1'b0;
  wire logic ev = ev_raw | (hold_reg != '0);
  wire logic blinky = (fn == FN_LINK_ACT) ? status_in.link & (act ? blink_in : 1'b1) :
                      (fn == FN_DUP_COL) ? (status_in.col ? blink_in : status_in.duplex) :
                      (fn == FN_LINK_RX) ? status_in.link & (status_in.rx ? blink_in : 1'b1) :
                      (fn == FN_1000_100) ? status_in.sp1000 | (status_in.sp100 & blink_in) :
                      1'b0;
  wire logic fn_on = (fn == FN_DUPLEX) ? status_in.duplex :
                     (fn == FN_1000) ? status_in.sp1000 :
                     (fn == FN_100) ? status_in.sp100 :
                     (fn == FN_10) ? status_in.sp10 :
                     (fn == FN_LINK) ? status_in.link :
                     (fn == FN_ACT || fn == FN_COL || fn == FN_TX || fn == FN_RX) ? ev :
                     blinky;
  wire logic lit_next = (force_sel == FORCE_ON) ? 1'b1 :
                        (force_sel == FORCE_OFF) ? 1'b0 :
                        (force_sel == FORCE_BLINK) ? blink_in : fn_on;

  // stretch restarts only at an event's rising start
  logic ev_d_reg;
  wire logic ev_start = ev_raw & ~ev_d_reg;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      hold_reg <= '0;
      ev_d_reg <= 1'b0;
      lit_reg <= 1'b0;
    end
    else
    begin
      ev_d_reg <= ev_raw;
      if (ev_start && stretch_en_in)
        hold_reg <= stretch_len_in;
      else if (hold_reg != '0)
        hold_reg <= hold_reg - 1'b1;
      lit_reg <= lit_next;
    end
  end

  assign lit_out = lit_reg;

endmodule : slc_led_drv

// *** hw/slc_top.sv ***
/*
  Strap latch and LED control: samples configuration straps during reset
  and hardware powerdown, keeps them as register defaults, then turns the
  shared pins into LED drivers. Registers sit on Avalon-MM with waitrequest.
  Assumes straps are synchronous to clk_in and settled while reset is low.
*/
// The register addresses and the Avalon-MM register port are this design's own decisions.
// Summary of operation
// - latch straps and shared LED pins during power-up, reset, powerdown recovery.
// - latched strap values become register defaults and are kept afterwards.
// - after reset release shared strap pins switch to driving LEDs.
// - gigabit strap deasserted removes gigabit from advertisement.
// - pause strap low advertises no pause, high advertises both pause kinds.
// - sysclk strap low during reset runs system clock output through reset.
// - energy-detect strap low enables low-power detect while deep sleep asserted.
// - in low-power detect mode, cable energy asserts the management interrupt.
// - three-bit mac interface strap selects the mac interface mode.
// - smallest package forces the top mac select bit to one.
// - straps 100 and 110 load mode 110; 100 sets delay bit, 110 clears.
// - straps 101 and 111 load mode 111; 101 sets delay bit, 111 clears.
// - latched one drives the LED low when lit, else high.
// - stretch period selectable among 28, 60 and 100 ms.
// - each LED can be forced on, off or blinking.
// - each LED can show one of thirteen status functions.
// - LED configuration lives in three LED control registers.
// - gigabit LED shows gigabit speed, link LED shows link, by default.
// - the two general-purpose LEDs are off after reset.
// - shared pins are inputs only while latching, LED drivers afterwards.
// - management interrupt is active low and open drain.
`timescale 1ns/1ps
module slc_top
  import slc_pkg::*;
#(
  parameter bit SMALL_PKG = 1'b0,
  parameter int unsigned STRETCH_28 = STRETCH_28_CYC,
  parameter int unsigned STRETCH_60 = STRETCH_60_CYC,
  parameter int unsigned STRETCH_100 = STRETCH_100_CYC,
  parameter int unsigned BLINK_HALF = BLINK_HALF_CYC
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic powerdown_in,
  input wire logic deep_sleep_input,
  input wire logic cable_energy_in,
  input wire slc_status_t link_status_in,
  input wire logic gig_adv_strap_in,
  input wire logic pause_strap_in,
  input wire logic sysclk_out_enable_strap_low,
  input wire logic energy_detect_enable_strap_low,
  input wire logic [2:0] mac_interface_select,
  input wire logic [3:0] led_pin_in,
  output logic [3:0] led_pin_out,
  output logic [3:0] led_pin_oe_n_out,
  output logic system_clock_output,
  output logic mgmt_int_low_out,
  output logic mgmt_int_oe_n_out,
  output logic low_power_energy_detect,
  output logic [2:0] adv_speed_out,
  output logic [1:0] adv_pause_out,
  output logic [2:0] mac_mode_out,
  output logic tx_delay_out,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  localparam int unsigned CNT_W = $clog2(STRETCH_100 + 1);
  if (STRETCH_28 < 1 || STRETCH_60 < STRETCH_28 || STRETCH_100 < STRETCH_60 || BLINK_HALF < 1)
  begin : g_bad_param
    $error("slc_top: stretch and blink counts must be ascending and nonzero");
  end

  // ------------------------------------------------------------
  // strap latch
  // ------------------------------------------------------------
  // latch window: reset held low or powerdown; the first edge after reset release still loads ports
  logic latch_open_reg;
  slc_strap_t strap_reg;
  wire logic [2:0] mac_sel_eff = {SMALL_PKG ? 1'b1 : mac_interface_select[2],
                                  mac_interface_select[1:0]};
  wire slc_strap_t strap_next = '{gig_adv: gig_adv_strap_in, pause: pause_strap_in,
                                  sysclk_en_low: sysclk_out_enable_strap_low,
                                  ed_en_low: energy_detect_enable_strap_low,
                                  mac_sel: mac_sel_eff, led_pol: led_pin_in};

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      latch_open_reg <= 1'b1;
    else
      latch_open_reg <= powerdown_in;
  end

  // plain clocked latch: samples while reset is low or the latch window is open, frozen otherwise
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in || latch_open_reg)
      strap_reg <= strap_next;
  end

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic [2:0] adv_speed_reg;
  logic [1:0] adv_pause_reg;
  logic [2:0] mac_mode_reg;
  logic tx_delay_reg;
  logic ed_en_reg;
  logic [31:0] led_ctrl1_reg;
  logic [31:0] led_ctrl2_reg;
  logic [31:0] led_ctrl3_reg;
  logic [31:0] rdata_reg;
  logic wait_reg;

  wire logic acc = (avs_read | avs_write) & wait_reg;
  wire logic wr = avs_write & ~wait_reg;
  wire logic hit_adv = avs_address == OFS_ADV;
  wire logic hit_macif = avs_address == OFS_MACIF;
  wire logic hit_lowpwr = avs_address == OFS_LOWPWR;
  wire logic hit_l1 = avs_address == OFS_LED_CTRL1;
  wire logic hit_l2 = avs_address == OFS_LED_CTRL2;
  wire logic hit_l3 = avs_address == OFS_LED_CTRL3;
  wire logic [31:0] bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // mac strap to mode and delay bit
  wire logic [2:0] mode_dflt = strap_reg.mac_sel[2] ?
                               (strap_reg.mac_sel[0] ? MACIF_RTBI_MODE : MACIF_RGMII_MODE) :
                               strap_reg.mac_sel;
  wire logic dly_dflt = strap_reg.mac_sel[2] & ~strap_reg.mac_sel[1];

  wire logic [31:0] rd_mux =
    (avs_address == OFS_STRAP) ? {21'h0, strap_reg} :
    hit_adv ? {27'h0, adv_pause_reg, adv_speed_reg} :
    hit_macif ? {28'h0, tx_delay_reg, mac_mode_reg} :
    hit_lowpwr ? {30'h0, low_power_energy_detect, ed_en_reg} :
    hit_l1 ? led_ctrl1_reg :
    hit_l2 ? led_ctrl2_reg :
    hit_l3 ? led_ctrl3_reg : 32'h0;

  // one wait state: answer at the second edge of every access
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0;
    end
    else
    begin
      wait_reg <= ~acc;
      if (acc && avs_read)
        rdata_reg <= rd_mux;
    end
  end

  // defaults reload while the strap window is open, then software owns them
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      adv_speed_reg <= 3'h7;
      adv_pause_reg <= 2'h0;
      mac_mode_reg <= 3'h0;
      tx_delay_reg <= 1'b0;
      ed_en_reg <= 1'b0;
      led_ctrl1_reg <= LED_CTRL1_RST;
      led_ctrl2_reg <= LED_CTRL2_RST;
      led_ctrl3_reg <= LED_CTRL3_RST;
    end
    else if (latch_open_reg)
    begin
      adv_speed_reg <= {strap_reg.gig_adv, 2'b11};
      adv_pause_reg <= {2{strap_reg.pause}};
      mac_mode_reg <= mode_dflt;
      tx_delay_reg <= dly_dflt;
      ed_en_reg <= ~strap_reg.ed_en_low;
    end
    else if (wr)
    begin
      if (hit_adv && avs_byteenable[0])
      begin
        adv_speed_reg <= avs_writedata[2:0];
        adv_pause_reg <= avs_writedata[4:3];
      end
      if (hit_macif && avs_byteenable[0])
      begin
        mac_mode_reg <= avs_writedata[2:0];
        tx_delay_reg <= avs_writedata[3];
      end
      if (hit_lowpwr && avs_byteenable[0])
        ed_en_reg <= avs_writedata[0];
      if (hit_l1)
        led_ctrl1_reg <= merge(led_ctrl1_reg, avs_writedata, bmask);
      if (hit_l2)
        led_ctrl2_reg <= merge(led_ctrl2_reg, avs_writedata, bmask);
      if (hit_l3)
        led_ctrl3_reg <= merge(led_ctrl3_reg, avs_writedata, bmask);
    end
  end

  // ------------------------------------------------------------
  // system clock, low-power detect, interrupt
  // ------------------------------------------------------------
  logic sysclk_reg;
  logic low_power_energy_detect_reg;
  logic int_drive_reg;
  wire logic low_power_energy_detect_next = ed_en_reg & deep_sleep_input;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sysclk_reg <= 1'b0;
      low_power_energy_detect_reg <= 1'b0;
      int_drive_reg <= 1'b0;
    end
    else
    begin
      sysclk_reg <= ~strap_reg.sysclk_en_low & ~sysclk_reg;
      low_power_energy_detect_reg <= low_power_energy_detect_next;
      int_drive_reg <= low_power_energy_detect_reg & cable_energy_in;
    end
  end

  // divide by two; runs through reset when the strap enabled it
  bit sysclk_rst_reg;
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      sysclk_rst_reg <= ~strap_next.sysclk_en_low & ~sysclk_rst_reg;
    else
      sysclk_rst_reg <= 1'b0;
  end

  assign system_clock_output = reset_n_in ? sysclk_reg : sysclk_rst_reg;
  assign low_power_energy_detect = low_power_energy_detect_reg;
  assign mgmt_int_low_out = 1'b0;
  assign mgmt_int_oe_n_out = ~int_drive_reg;

  // ------------------------------------------------------------
  // LED drivers
  // ------------------------------------------------------------
  logic [31:0] blink_cnt_reg;
  logic blink_reg;
  logic [3:0] led_pin_reg;
  logic [3:0] led_oe_n_reg;
  wire logic [1:0] st_sel = led_ctrl3_reg[STRETCH_SEL_LSB +: 2];
  wire logic [CNT_W-1:0] st_len = (st_sel == 2'h0) ? CNT_W'(STRETCH_28) :
                                  (st_sel == 2'h1) ? CNT_W'(STRETCH_60) :
                                  CNT_W'(STRETCH_100);
  wire logic [31:0] ctrl_all = {led_ctrl2_reg[15:0], led_ctrl1_reg[15:0]};
  wire logic [3:0] lit;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= 1'b0;
      led_pin_reg <= 4'h0;
      led_oe_n_reg <= 4'hf;
    end
    else
    begin
      blink_cnt_reg <= (blink_cnt_reg >= 32'(BLINK_HALF - 1)) ? 32'h0 : blink_cnt_reg + 32'h1;
      if (blink_cnt_reg >= 32'(BLINK_HALF - 1))
        blink_reg <= ~blink_reg;
      led_pin_reg <= lit ^ strap_reg.led_pol;
      led_oe_n_reg <= {4{latch_open_reg}};
    end
  end

  for (genvar i = 0; i < 4; i++)
  begin : g_led
    slc_led_drv #(.CNT_W(CNT_W)) u_drv (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .ctrl_in(ctrl_all[i*LED_STRIDE +: LED_STRIDE]),
      .status_in(link_status_in),
      .blink_in(blink_reg),
      .stretch_en_in(led_ctrl3_reg[STRETCH_EN_BIT]),
      .stretch_len_in(st_len),
      .lit_out(lit[i])
    );
  end

  assign led_pin_out = led_pin_reg;
  assign led_pin_oe_n_out = led_oe_n_reg;
  assign adv_speed_out = adv_speed_reg;
  assign adv_pause_out = adv_pause_reg;
  assign mac_mode_out = mac_mode_reg;
  assign tx_delay_out = tx_delay_reg;
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;

endmodule : slc_top

// *** bench/slc_top_props.sv ***
/*
  Checker for the strap latch and LED control top: bus answer timing,
  pin release, low-power detect and interrupt behaviour.
  Assumes a single clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
module slc_top_props
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic powerdown_in,
  input wire logic deep_sleep_input,
  input wire logic cable_energy_in,
  input wire logic [3:0] led_pin_oe_n_out,
  input wire logic mgmt_int_low_out,
  input wire logic mgmt_int_oe_n_out,
  input wire logic low_power_energy_detect,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("bus request not answered next cycle");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low for more than one cycle");
  property p_unmapped;
    avs_read && avs_waitrequest && avs_address == 8'h40 |=> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_pd_release;
    $past(powerdown_in, 2) |-> led_pin_oe_n_out == 4'hf;
  endproperty
  a_pd_release: assert property (p_pd_release) else $error("led pins driven during powerdown");
  property p_run_drive;
    !powerdown_in [*4] |-> led_pin_oe_n_out == 4'h0;
  endproperty
  a_run_drive: assert property (p_run_drive) else $error("led pins not driven after latch");
  property p_low_power_energy_detect_off;
    !deep_sleep_input |=> !low_power_energy_detect;
  endproperty
  a_low_power_energy_detect_off: assert property (p_low_power_energy_detect_off) else $error("energy detect without deep sleep");
  property p_int_raise;
    (low_power_energy_detect && cable_energy_in) [*2] |=> !mgmt_int_oe_n_out;
  endproperty
  a_int_raise: assert property (p_int_raise) else $error("interrupt not raised on energy");
  property p_int_cause;
    $fell(mgmt_int_oe_n_out) |-> $past(low_power_energy_detect) && $past(cable_energy_in);
  endproperty
  a_int_cause: assert property (p_int_cause) else $error("interrupt raised without cause");
  property p_int_level;
    mgmt_int_low_out == 1'b0;
  endproperty
  a_int_level: assert property (p_int_level) else $error("interrupt pin drives high");
endmodule : slc_top_props

bind slc_top slc_top_props u_slc_top_props (.clk_in(clk_in), .reset_n_in(reset_n_in), .powerdown_in(powerdown_in),
  .deep_sleep_input(deep_sleep_input), .cable_energy_in(cable_energy_in), .led_pin_oe_n_out(led_pin_oe_n_out),
  .mgmt_int_low_out(mgmt_int_low_out), .mgmt_int_oe_n_out(mgmt_int_oe_n_out),
  .low_power_energy_detect(low_power_energy_detect), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// *** bench/slc_board.sv ***
/*
  Board model: strap resistors on every strap pin, LEDs on the shared pins
  and a pull-up on the interrupt line.
  Assumes the bench chooses the fitted strap pattern.
*/
`timescale 1ns/1ps
module slc_board
  import slc_pkg::*;
(
  input wire slc_strap_t fit_in,
  input wire logic [3:0] led_drv_in,
  input wire logic [3:0] led_oe_n_in,
  input wire logic int_drv_in,
  input wire logic int_oe_n_in,
  output slc_strap_t strap_out,
  output logic [3:0] led_wire_out,
  output logic [3:0] lit_out,
  output logic int_wire_out
);
  assign strap_out = fit_in;
  // released pin falls back to its strap resistor level
  assign led_wire_out = (led_oe_n_in & fit_in.led_pol) | (~led_oe_n_in & led_drv_in);
  // led glows when pulled away from its resistor level
  assign lit_out = ~led_oe_n_in & (led_wire_out ^ fit_in.led_pol);
  assign int_wire_out = int_oe_n_in ? 1'b1 : int_drv_in;
endmodule : slc_board

// *** bench/testbench.sv ***
/*
  Testbench for the strap latch and LED control top: register access over
  Avalon-MM, strap sweeps through reset and powerdown, LED functions.
  Assumes slc_board as the far side and shortened stretch and blink counts.
*/
`timescale 1ns/1ps
module testbench
  import slc_pkg::*;
;
  localparam int unsigned ST0 = 20;
  localparam int unsigned ST1 = 40;
  localparam int unsigned ST2 = 60;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic powerdown_in = 1'b0;
  logic deep_sleep_input = 1'b0;
  logic cable_energy_in = 1'b0;
  slc_status_t link_status_in = 8'h00;
  slc_strap_t fit = 11'h000;
  slc_strap_t strap;
  logic [3:0] led_pin_in, led_pin_out, led_pin_oe_n_out, lit, avs_byteenable = 4'hf;
  logic system_clock_output, mgmt_int_low_out, mgmt_int_oe_n_out, low_power_energy_detect, tx_delay_out, int_wire;
  logic [2:0] adv_speed_out, mac_mode_out;
  logic [1:0] adv_pause_out;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  int err_total = 0, n_tests = 0;

  always #4 clk_in = ~clk_in;

  slc_top #(.STRETCH_28(ST0), .STRETCH_60(ST1), .STRETCH_100(ST2), .BLINK_HALF(8)) u_slc_top (.clk_in, .reset_n_in,
    .powerdown_in, .deep_sleep_input, .cable_energy_in, .link_status_in, .gig_adv_strap_in(strap.gig_adv),
    .pause_strap_in(strap.pause), .sysclk_out_enable_strap_low(strap.sysclk_en_low),
    .energy_detect_enable_strap_low(strap.ed_en_low), .mac_interface_select(strap.mac_sel), .led_pin_in,
    .led_pin_out, .led_pin_oe_n_out, .system_clock_output, .mgmt_int_low_out, .mgmt_int_oe_n_out,
    .low_power_energy_detect, .adv_speed_out, .adv_pause_out, .mac_mode_out, .tx_delay_out, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);

  slc_board u_slc_board (.fit_in(fit), .led_drv_in(led_pin_out), .led_oe_n_in(led_pin_oe_n_out),
    .int_drv_in(mgmt_int_low_out), .int_oe_n_in(mgmt_int_oe_n_out), .strap_out(strap), .led_wire_out(led_pin_in),
    .lit_out(lit), .int_wire_out(int_wire));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task give_verdict;
    $display("mismatches %0d comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one request held until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 64)
    begin
      err_total++;
      give_verdict();
    end
  endtask : bus

  task do_reset(input slc_strap_t f);
    int t;
    logic prev;
    fit <= f;
    reset_n_in <= 1'b0;
    @(posedge clk_in);
    prev = system_clock_output;
    t = 0;
    repeat (7)
    begin
      @(posedge clk_in);
      if (system_clock_output !== prev)
        t++;
      prev = system_clock_output;
    end
    check("sysclk in reset", t > 2, !f.sysclk_en_low);
    reset_n_in <= 1'b1;
    repeat (5) @(posedge clk_in);
  endtask : do_reset

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    slc_strap_t f;
    logic [15:0] fn_exp;
    int t;
    logic prev;
    int len [3];
    len = '{ST0, ST1, ST2};
    fn_exp = 16'h065e;
    link_status_in <= 8'hc4;
    for (int m = 0; m < 8; m++)
    begin
      f = {m[0], m[1], m[1], m[0], m[2:0], m[1:0], ~m[1:0]};
      do_reset(f);
      check("adv speed", adv_speed_out, {f.gig_adv, 2'b11});
      check("adv pause", adv_pause_out, {2{f.pause}});
      if (m != 3)
        check("mac mode", mac_mode_out, m[2] ? {2'b11, m[0]} : m[2:0]);
      if (m >= 4)
        check("tx delay", tx_delay_out, !m[1]);
      check("pins driving", led_pin_oe_n_out, 4'h0);
      check("lit", lit, 4'h3);
      bus(1'b0, OFS_STRAP, 32'h0);
      check("strap reg", rd, {21'h0, f});
      bus(1'b0, OFS_LOWPWR, 32'h0);
      check("ed enable", rd[0], !f.ed_en_low);
      bus(1'b0, OFS_LED_CTRL2, 32'h0);
      check("gp ctrl", rd, LED_CTRL2_RST);
    end
    do_reset(11'h525);
    deep_sleep_input <= 1'b1;
    repeat (3) @(posedge clk_in);
    check("low_power_energy_detect", low_power_energy_detect, 1'b1);
    cable_energy_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    check("int line", int_wire, 1'b0);
    deep_sleep_input <= 1'b0;
    cable_energy_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check("low_power_energy_detect off", low_power_energy_detect, 1'b0);
    for (int i = 0; i < 13; i++)
    begin
      bus(1'b1, OFS_LED_CTRL1, {16'h0, 8'h0a, 4'h0, i[3:0]});
      repeat (3) @(posedge clk_in);
      check("function", lit[0], fn_exp[i]);
    end
    avs_byteenable <= 4'h2;
    bus(1'b1, OFS_LED_CTRL1, 32'hffff_2aff);
    avs_byteenable <= 4'hf;
    bus(1'b0, OFS_LED_CTRL1, 32'h0);
    check("ctrl1 lanes", rd, 32'h0000_2a0c);
    check("forced off", lit[1], 1'b0);
    bus(1'b1, OFS_LED_CTRL2, 32'h0000_2010);
    repeat (3) @(posedge clk_in);
    check("forced on", lit[2], 1'b1);
    bus(1'b1, OFS_LED_CTRL2, 32'h0000_2030);
    prev = lit[2];
    t = 0;
    repeat (40)
    begin
      @(posedge clk_in);
      if (lit[2] !== prev)
        t++;
      prev = lit[2];
    end
    check("blink", t >= 4 && t <= 6, 1'b1);
    // transmit activity on the gigabit led shows stretching
    bus(1'b1, OFS_LED_CTRL1, 32'h0000_0a0b);
    for (int s = 0; s < 3; s++)
    begin
      bus(1'b1, OFS_LED_CTRL3, {29'h0, 1'b1, s[1:0]});
      @(posedge clk_in);
      link_status_in <= 8'hd4;
      @(posedge clk_in);
      link_status_in <= 8'hc4;
      repeat (len[s] - 6) @(posedge clk_in);
      check("stretched", lit[0], 1'b1);
      repeat (16) @(posedge clk_in);
      check("stretch end", lit[0], 1'b0);
    end
    powerdown_in <= 1'b1;
    fit <= 11'h39a;
    repeat (4) @(posedge clk_in);
    check("pins released", led_pin_oe_n_out, 4'hf);
    powerdown_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    bus(1'b0, OFS_STRAP, 32'h0);
    check("relatched", rd, 32'h0000_039a);
    check("mode relatched", mac_mode_out, 3'b001);
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped", rd, 32'h0);
    give_verdict();
  end

  initial
  begin
    repeat (100000) @(posedge clk_in);
    err_total++;
    give_verdict();
  end
endmodule : testbench
